/* common/tmcap_defs.svh */
`ifndef TMCAP_DEFS_SVH
`define TMCAP_DEFS_SVH

// Register offsets (8-bit register port)
`define TMCAP_OFS_FIRST_COUNT    8'h00
`define TMCAP_OFS_SECOND_COUNT   8'h01
`define TMCAP_OFS_FIRST_PERIOD   8'h02
`define TMCAP_OFS_SECOND_PERIOD  8'h03
`define TMCAP_OFS_WIDE_LOW       8'h04
`define TMCAP_OFS_WIDE_HIGH      8'h05
`define TMCAP_OFS_PCA_LOW        8'h06
`define TMCAP_OFS_PCA_HIGH       8'h07
`define TMCAP_OFS_CAP2_LOW       8'h08
`define TMCAP_OFS_CAP2_HIGH      8'h09
`define TMCAP_OFS_STATUS         8'h0a
`define TMCAP_OFS_ENABLE         8'h0b
`define TMCAP_OFS_CONTROL        8'h16

// Control register fields
`define TMCAP_CTL_CAP2_MSB       7
`define TMCAP_CTL_CAP2_LSB       6
`define TMCAP_CTL_CAP1_MSB       5
`define TMCAP_CTL_CAP1_LSB       4
`define TMCAP_CTL_COMBINE        3
`define TMCAP_CTL_WIDE_CS        2
`define TMCAP_CTL_SECOND_CS      1
`define TMCAP_CTL_FIRST_CS       0

// Status flags, write one to clear
`define TMCAP_ST_FIRST_OVF       0
`define TMCAP_ST_SECOND_OVF      1
`define TMCAP_ST_WIDE_OVF        2
`define TMCAP_ST_CAP1            3
`define TMCAP_ST_CAP2            4
`define TMCAP_ST_MASK            8'h1f

// Enable register fields
`define TMCAP_EN_CAP1_MODE       0
`define TMCAP_EN_FIRST_RUN       1
`define TMCAP_EN_SECOND_RUN      2
`define TMCAP_EN_WIDE_RUN        3
`define TMCAP_EN_MASK            8'h0f

// Reset values
`define TMCAP_RST_CONTROL        8'h00
`define TMCAP_RST_ENABLE         8'h00
`define TMCAP_RST_PERIOD         8'hff
`define TMCAP_RST_ZERO           8'h00

// Instruction cycle is four oscillator clocks
`define TMCAP_INSN_DIV           4
// Prescaler counts at which the 4th and 16th rising edge fire a capture
`define TMCAP_PRE_FOUR           4'h3
`define TMCAP_PRE_SIXTEEN        4'hf

`endif

/* common/tmcap_pkg.sv */
`default_nettype none
package tmcap_pkg;

  // Capture trigger selection
  typedef enum logic [1:0] {
    tmcap_edge_fall    = 2'b00,
    tmcap_edge_rise    = 2'b01,
    tmcap_edge_rise4   = 2'b10,
    tmcap_edge_rise16  = 2'b11
  } tmcap_edge_t;

  typedef logic [7:0] tmcap_byte_t;

endpackage
`default_nettype wire

/* common/tmcap_cap_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries one capture channel between the core and its trigger unit
interface tmcap_cap_if;
  import tmcap_pkg::*;
  logic        rise;
  logic        fall;
  logic        enable;
  tmcap_edge_t mode;
  logic        fire;
  modport unit (input rise, input fall, input enable, input mode, output fire);
  modport core (output rise, output fall, output enable, output mode, input fire);
endinterface
`default_nettype wire

/* rtl/tmcap_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module tmcap_sync
  import tmcap_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("tmcap_sync: WIDTH must be at least 1");
    end
  endgenerate

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] lvl_ff;
  logic [WIDTH-1:0] old_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_lvl;
  logic [WIDTH-1:0] nxt_old;

  // The first stage feeds only the second; edges come from later stages
  always_comb
  begin
    nxt_meta = din;
    nxt_lvl  = meta_ff;
    nxt_old  = lvl_ff;
  end

  // No reset on the chain: it flushes to the pin level while reset is held,
  // so no false edge follows release whatever the pin's idle level
  always_ff @(posedge mclk)
  begin
    meta_ff <= nxt_meta;
    lvl_ff  <= nxt_lvl;
    old_ff  <= nxt_old;
  end

  // One-cycle edge pulses, held off during reset
  assign rise = lvl_ff & ~old_ff & ~{WIDTH{rst}};
  assign fall = ~lvl_ff & old_ff & ~{WIDTH{rst}};

endmodule // tmcap_sync
`default_nettype wire

/* rtl/tmcap_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module tmcap_capture
  import tmcap_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  rst,
  tmcap_cap_if.unit  bus
);
`include "tmcap_defs.svh"

  logic [3:0] pre_ff;
  logic [3:0] nxt_pre;
  logic       fire_ff;
  logic       nxt_fire;

  // Trigger selection; prescaler restarts while the channel is idle
  always_comb
  begin
    nxt_pre  = pre_ff;
    nxt_fire = 1'b0;
    if (!bus.enable)
    begin
      nxt_pre = 4'h0;
    end
    else
    begin
      case (bus.mode)
        tmcap_edge_fall:  nxt_fire = bus.fall; // [RULE_10] [RULE_11]
        tmcap_edge_rise:  nxt_fire = bus.rise; // [RULE_10] [RULE_11]
        tmcap_edge_rise4:
        begin
          if (bus.rise)
          begin
            nxt_fire = (pre_ff[1:0] == 2'(`TMCAP_PRE_FOUR)); // Every 4th rise [RULE_10]
            nxt_pre  = nxt_fire ? 4'h0 : pre_ff + 4'h1;
          end
        end
        default:
        begin
          if (bus.rise)
          begin
            nxt_fire = (pre_ff == `TMCAP_PRE_SIXTEEN); // Every 16th rise [RULE_11]
            nxt_pre  = nxt_fire ? 4'h0 : pre_ff + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pre_ff  <= 4'h0;
      fire_ff <= 1'b0;
    end
    else
    begin
      pre_ff  <= nxt_pre;
      fire_ff <= nxt_fire;
    end
  end

  assign bus.fire = fire_ff;

endmodule // tmcap_capture
`default_nettype wire

/* rtl/tmcap_timers.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01 - Two independent 8-bit up timers, each with period register and overflow flag.
// RULE_02 - Byte timers advance per instruction cycle or on shared pin falling edges.
// RULE_03 - Software can join both byte timers into one 16-bit timer.
// RULE_04 - Byte timers provide the time base for pulse-width outputs.
// RULE_05 - Third timer is 16 bits, held in high and low byte registers.
// RULE_06 - One register pair is the third timer period or capture one result.
// RULE_07 - A second register pair holds only capture two results.
// RULE_08 - Both captures sample the third timer as common time base.
// RULE_09 - Third timer counts internal clock or its external count pin.
// RULE_10 - Control bits 7:6 pick capture two trigger: fall, rise, 4th, 16th rise.
// RULE_11 - Control bits 5:4 pick capture one trigger with the same encoding.
// RULE_12 - Control bit 3 set joins byte timers into 16 bits; clear keeps two.
// RULE_13 - Control bit 2 set counts wide pin falling edges; clear internal clock.
// RULE_14 - Control bits 1 and 0 select shared pin or internal clock per byte timer.
// RULE_15 - A capture event copies the third timer count into its result pair.
// RULE_16 - A byte timer matching its period sets its flag and restarts at zero.
`include "tmcap_defs.svh"
module tmcap_timers
  import tmcap_pkg::*;
#(
  parameter int INSN_DIV = `TMCAP_INSN_DIV
)
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        shared_count_pin,
  input  wire logic        wide_timer_count_pin,
  input  wire logic        capture_one_pin,
  input  wire logic        capture_two_pin,
  output logic      [7:0]  pwm_base_first,
  output logic      [7:0]  pwm_base_second,
  output logic             pwm_base_first_wrap,
  output logic             pwm_base_second_wrap
);

  generate
    if (INSN_DIV < 2 || INSN_DIV > 256)
    begin : g_chk
      $error("tmcap_timers: INSN_DIV must be 2 to 256");
    end
  endgenerate

  // Write decode shared by every writable register
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = reg_wr && (reg_addr == ofs);
  endfunction

  // Pin synchronisers and edge pulses
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  tmcap_sync #(.WIDTH(4)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({capture_two_pin, capture_one_pin, wide_timer_count_pin, shared_count_pin}),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  logic [7:0] ctl_ff;
  logic [7:0] en_ff;
  logic [7:0] st_ff;
  logic [7:0] first_ff;
  logic [7:0] second_ff;
  logic [7:0] per1_ff;
  logic [7:0] per2_ff;
  logic [15:0] wide_ff;
  logic [15:0] pca_ff;
  logic [15:0] cap2_ff;
  logic        wrap1_ff;
  logic        wrap2_ff;
  logic [7:0]  div_ff;
  logic [7:0]  rdata_ff;

  logic [7:0]  nxt_ctl;
  logic [7:0]  nxt_en;
  logic [7:0]  nxt_st;
  logic [7:0]  nxt_first;
  logic [7:0]  nxt_second;
  logic [7:0]  nxt_per1;
  logic [7:0]  nxt_per2;
  logic [15:0] nxt_wide;
  logic [15:0] nxt_pca;
  logic [15:0] nxt_cap2;
  logic        nxt_wrap1;
  logic        nxt_wrap2;
  logic [7:0]  nxt_div;
  logic [7:0]  nxt_rdata;

  // Capture trigger units
  tmcap_cap_if cap_bus [2] ();
  logic [1:0]  cap_fire;
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_cap
      assign cap_bus[g].rise   = pin_rise[2+g];
      assign cap_bus[g].fall   = pin_fall[2+g];
      // Channel one only triggers while its pair is in capture role
      assign cap_bus[g].enable = (g == 0) ? en_ff[`TMCAP_EN_CAP1_MODE] : 1'b1; // [RULE_06]
      assign cap_bus[g].mode   = (g == 0) ?
                                 tmcap_edge_t'(ctl_ff[`TMCAP_CTL_CAP1_MSB:`TMCAP_CTL_CAP1_LSB]) :
                                 tmcap_edge_t'(ctl_ff[`TMCAP_CTL_CAP2_MSB:`TMCAP_CTL_CAP2_LSB]);
      assign cap_fire[g]       = cap_bus[g].fire;
      tmcap_capture u_cap (
        .mclk (mclk),
        .rst  (rst),
        .bus  (cap_bus[g])
      );
    end
  endgenerate

  logic insn_tick;
  logic tick1;
  logic tick2;
  logic tick3;
  logic combine;
  logic cap_mode;

  assign insn_tick = (div_ff == 8'(INSN_DIV - 1));
  assign combine   = ctl_ff[`TMCAP_CTL_COMBINE]; // [RULE_12]
  assign cap_mode  = en_ff[`TMCAP_EN_CAP1_MODE];
  // Clock source per timer
  assign tick1 = en_ff[`TMCAP_EN_FIRST_RUN] &&
                 (ctl_ff[`TMCAP_CTL_FIRST_CS] ? pin_fall[0] : insn_tick);   // [RULE_02] [RULE_14]
  assign tick2 = en_ff[`TMCAP_EN_SECOND_RUN] &&
                 (ctl_ff[`TMCAP_CTL_SECOND_CS] ? pin_fall[0] : insn_tick);  // [RULE_02] [RULE_14]
  assign tick3 = en_ff[`TMCAP_EN_WIDE_RUN] &&
                 (ctl_ff[`TMCAP_CTL_WIDE_CS] ? pin_fall[1] : insn_tick);    // [RULE_09] [RULE_13]

  // Timer and register next state; software writes win over counting,
  // hardware flag sets win over a same-cycle clear
  always_comb
  begin
    nxt_div    = insn_tick ? 8'h00 : div_ff + 8'h01;
    nxt_ctl    = ctl_ff;
    nxt_en     = en_ff;
    nxt_st     = st_ff;
    nxt_first  = first_ff;
    nxt_second = second_ff;
    nxt_per1   = per1_ff;
    nxt_per2   = per2_ff;
    nxt_wide   = wide_ff;
    nxt_pca    = pca_ff;
    nxt_cap2   = cap2_ff;
    nxt_wrap1  = 1'b0;
    nxt_wrap2  = 1'b0;

    // Byte timers, joined or separate
    if (combine)
    begin
      if (tick1)
      begin
        if ({second_ff, first_ff} == {per2_ff, per1_ff}) // [RULE_03]
        begin
          {nxt_second, nxt_first} = 16'h0000;
          nxt_wrap1 = 1'b1;
          nxt_wrap2 = 1'b1;
        end
        else
        begin
          {nxt_second, nxt_first} = {second_ff, first_ff} + 16'h0001; // [RULE_03]
        end
      end
    end
    else
    begin
      if (tick1)
      begin
        nxt_wrap1 = (first_ff == per1_ff);                            // [RULE_16]
        nxt_first = nxt_wrap1 ? 8'h00 : first_ff + 8'h01;             // [RULE_01]
      end
      if (tick2)
      begin
        nxt_wrap2  = (second_ff == per2_ff);                          // [RULE_16]
        nxt_second = nxt_wrap2 ? 8'h00 : second_ff + 8'h01;           // [RULE_01]
      end
    end

    // Wide timer: period restart only while the pair is a period
    if (tick3)
    begin
      if (!cap_mode && wide_ff == pca_ff)
      begin
        nxt_wide = 16'h0000; // [RULE_06]
      end
      else
      begin
        nxt_wide = wide_ff + 16'h0001; // [RULE_05]
      end
    end

    // Register writes
    if (wr_hit(`TMCAP_OFS_CONTROL))       nxt_ctl    = reg_wdata;
    if (wr_hit(`TMCAP_OFS_ENABLE))        nxt_en     = reg_wdata & `TMCAP_EN_MASK;
    if (wr_hit(`TMCAP_OFS_FIRST_COUNT))   nxt_first  = reg_wdata;
    if (wr_hit(`TMCAP_OFS_SECOND_COUNT))  nxt_second = reg_wdata;
    if (wr_hit(`TMCAP_OFS_FIRST_PERIOD))  nxt_per1   = reg_wdata;
    if (wr_hit(`TMCAP_OFS_SECOND_PERIOD)) nxt_per2   = reg_wdata;
    if (wr_hit(`TMCAP_OFS_WIDE_LOW))      nxt_wide[7:0]  = reg_wdata; // [RULE_05]
    if (wr_hit(`TMCAP_OFS_WIDE_HIGH))     nxt_wide[15:8] = reg_wdata; // [RULE_05]
    if (wr_hit(`TMCAP_OFS_PCA_LOW))       nxt_pca[7:0]   = reg_wdata;
    if (wr_hit(`TMCAP_OFS_PCA_HIGH))      nxt_pca[15:8]  = reg_wdata;
    if (wr_hit(`TMCAP_OFS_STATUS))        nxt_st     = st_ff & ~reg_wdata;

    // Captures take the live wide count; the event beats a software write
    if (cap_fire[0])
    begin
      nxt_pca = wide_ff;                 // [RULE_06] [RULE_08] [RULE_15]
      nxt_st[`TMCAP_ST_CAP1] = 1'b1;
    end
    if (cap_fire[1])
    begin
      nxt_cap2 = wide_ff;                // [RULE_07] [RULE_08] [RULE_15]
      nxt_st[`TMCAP_ST_CAP2] = 1'b1;
    end

    // Overflow flags set after any clear so the event is never lost
    if (nxt_wrap1)
    begin
      nxt_st[`TMCAP_ST_FIRST_OVF] = 1'b1;    // [RULE_01] [RULE_16]
    end
    if (nxt_wrap2 && !combine)
    begin
      nxt_st[`TMCAP_ST_SECOND_OVF] = 1'b1;   // [RULE_01] [RULE_16]
    end
    if (tick3 && (cap_mode || wide_ff != pca_ff) && wide_ff == 16'hffff)
    begin
      nxt_st[`TMCAP_ST_WIDE_OVF] = 1'b1;
    end
    if (tick3 && !cap_mode && wide_ff == pca_ff)
    begin
      nxt_st[`TMCAP_ST_WIDE_OVF] = 1'b1;
    end
    nxt_st = nxt_st & `TMCAP_ST_MASK;
  end

  // Read data valid only in the cycle after the strobe
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr == `TMCAP_OFS_FIRST_COUNT)        nxt_rdata = first_ff;
      else if (reg_addr == `TMCAP_OFS_SECOND_COUNT)  nxt_rdata = second_ff;
      else if (reg_addr == `TMCAP_OFS_FIRST_PERIOD)  nxt_rdata = per1_ff;
      else if (reg_addr == `TMCAP_OFS_SECOND_PERIOD) nxt_rdata = per2_ff;
      else if (reg_addr == `TMCAP_OFS_WIDE_LOW)      nxt_rdata = wide_ff[7:0];
      else if (reg_addr == `TMCAP_OFS_WIDE_HIGH)     nxt_rdata = wide_ff[15:8];
      else if (reg_addr == `TMCAP_OFS_PCA_LOW)       nxt_rdata = pca_ff[7:0];
      else if (reg_addr == `TMCAP_OFS_PCA_HIGH)      nxt_rdata = pca_ff[15:8];
      else if (reg_addr == `TMCAP_OFS_CAP2_LOW)      nxt_rdata = cap2_ff[7:0];
      else if (reg_addr == `TMCAP_OFS_CAP2_HIGH)     nxt_rdata = cap2_ff[15:8];
      else if (reg_addr == `TMCAP_OFS_STATUS)        nxt_rdata = st_ff;
      else if (reg_addr == `TMCAP_OFS_ENABLE)        nxt_rdata = en_ff;
      else if (reg_addr == `TMCAP_OFS_CONTROL)       nxt_rdata = ctl_ff;
      else                                           nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      div_ff    <= 8'h00;
      ctl_ff    <= `TMCAP_RST_CONTROL;
      en_ff     <= `TMCAP_RST_ENABLE;
      st_ff     <= `TMCAP_RST_ZERO;
      first_ff  <= `TMCAP_RST_ZERO;
      second_ff <= `TMCAP_RST_ZERO;
      per1_ff   <= `TMCAP_RST_PERIOD;
      per2_ff   <= `TMCAP_RST_PERIOD;
      wide_ff   <= 16'h0000;
      pca_ff    <= {`TMCAP_RST_PERIOD, `TMCAP_RST_PERIOD};
      cap2_ff   <= 16'h0000;
      wrap1_ff  <= 1'b0;
      wrap2_ff  <= 1'b0;
      rdata_ff  <= 8'h00;
    end
    else
    begin
      div_ff    <= nxt_div;
      ctl_ff    <= nxt_ctl;
      en_ff     <= nxt_en;
      st_ff     <= nxt_st;
      first_ff  <= nxt_first;
      second_ff <= nxt_second;
      per1_ff   <= nxt_per1;
      per2_ff   <= nxt_per2;
      wide_ff   <= nxt_wide;
      pca_ff    <= nxt_pca;
      cap2_ff   <= nxt_cap2;
      wrap1_ff  <= nxt_wrap1;
      wrap2_ff  <= nxt_wrap2;
      rdata_ff  <= nxt_rdata;
    end
  end

  // Time base handed to the pulse-width outputs
  assign pwm_base_first       = first_ff;   // [RULE_04]
  assign pwm_base_second      = second_ff;  // [RULE_04]
  assign pwm_base_first_wrap  = wrap1_ff;   // [RULE_04]
  assign pwm_base_second_wrap = wrap2_ff;   // [RULE_04]
  assign reg_rdata            = rdata_ff;

endmodule // tmcap_timers
`default_nettype wire

/* dv/tmcap_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far side of the block: the four pins, idle high, changed right after a clock edge
module tmcap_pins_model
(
  input  wire logic mclk,
  output logic      shared_count_pin,
  output logic      wide_timer_count_pin,
  output logic      capture_one_pin,
  output logic      capture_two_pin
);
  logic [3:0] pin_lvl = 4'hf;

  // Pin order: shared count, wide count, capture one, capture two
  assign shared_count_pin     = pin_lvl[0];
  assign wide_timer_count_pin = pin_lvl[1];
  assign capture_one_pin      = pin_lvl[2];
  assign capture_two_pin      = pin_lvl[3];

  // Holds a level for a number of clocks; long holds model a slow source
  task automatic drive(input int pin, input logic lvl, input int hold);
    pin_lvl[pin] <= lvl;
    repeat (hold) @(posedge mclk);
  endtask

  // Low then high pulses; each gives one falling and one rising edge
  task automatic pulse(input int pin, input int n, input int hold);
    repeat (n)
    begin
      drive(pin, 1'b0, hold);
      drive(pin, 1'b1, hold);
    end
  endtask
endmodule // tmcap_pins_model
`default_nettype wire

/* dv/tmcap_timers_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Port checks; counts may only step by one or restart unless software writes
module tmcap_timers_monitor
  import tmcap_pkg::*;
#(
  parameter int INSN_DIV = 4
)
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       shared_count_pin,
  input wire logic       wide_timer_count_pin,
  input wire logic       capture_one_pin,
  input wire logic       capture_two_pin,
  input wire logic [7:0] pwm_base_first,
  input wire logic [7:0] pwm_base_second,
  input wire logic       pwm_base_first_wrap,
  input wire logic       pwm_base_second_wrap
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Read data stands only in the cycle after a read strobe
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  // Reset leaves both byte counts at zero
  property p_rst_zero; $past(rst) |-> {pwm_base_first, pwm_base_second} == 16'h0000; endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("count not cleared");
  // Without a write a count only steps up by one or restarts
  property p_step_first; $changed(pwm_base_first) && !$past(reg_wr) |->
    pwm_base_first == 8'($past(pwm_base_first) + 8'h01) || pwm_base_first == 8'h00; endproperty
  a_step_first: assert property (p_step_first) else $error("first count jumped");
  property p_step_second; $changed(pwm_base_second) && !$past(reg_wr) |->
    pwm_base_second == 8'($past(pwm_base_second) + 8'h01) || pwm_base_second == 8'h00; endproperty
  a_step_second: assert property (p_step_second) else $error("second count jumped");
  // A tick is never two cycles running, so a step is followed by a still cycle
  property p_gap_first; $changed(pwm_base_first) && !$past(reg_wr) && !reg_wr
    |=> $stable(pwm_base_first); endproperty
  a_gap_first: assert property (p_gap_first) else $error("first count too fast");
  property p_gap_second; $changed(pwm_base_second) && !$past(reg_wr) && !reg_wr
    |=> $stable(pwm_base_second); endproperty
  a_gap_second: assert property (p_gap_second) else $error("second count too fast");
  // A wrap pulse sees the count restarted and lasts one cycle
  property p_wrap_first; pwm_base_first_wrap |-> pwm_base_first == 8'h00 ##1 !pwm_base_first_wrap;
  endproperty
  a_wrap_first: assert property (p_wrap_first) else $error("first wrap wrong");
  property p_wrap_second; pwm_base_second_wrap |-> pwm_base_second == 8'h00 ##1
    !pwm_base_second_wrap; endproperty
  a_wrap_second: assert property (p_wrap_second) else $error("second wrap wrong");

  // Main scenarios
  c_wrap_pair: cover property (pwm_base_first_wrap && pwm_base_second_wrap);
  c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
  c_step: cover property ($changed(pwm_base_second) && !$past(reg_wr));
endmodule // tmcap_timers_monitor

bind tmcap_timers tmcap_timers_monitor #(.INSN_DIV(INSN_DIV)) i_tmcap_timers_monitor (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shared_count_pin(shared_count_pin),
  .wide_timer_count_pin(wide_timer_count_pin), .capture_one_pin(capture_one_pin),
  .capture_two_pin(capture_two_pin), .pwm_base_first(pwm_base_first),
  .pwm_base_second(pwm_base_second), .pwm_base_first_wrap(pwm_base_first_wrap),
  .pwm_base_second_wrap(pwm_base_second_wrap)
);
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tmcap_defs.svh"
module tb;
  localparam int DIV = 2;
  logic       mclk      = 1'b0;
  logic       rst       = 1'b1;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] base1;
  logic [7:0] base2;
  logic       wrap1;
  logic       wrap2;
  wire        pin_sh;
  wire        pin_wd;
  wire        pin_c1;
  wire        pin_c2;
  int         bad_count   = 0;
  int         check_count = 0;

  // 50 MHz clock
  always #10 mclk = ~mclk;

  // Short instruction tick keeps the joined-mode period walk brief
  tmcap_timers #(.INSN_DIV(DIV)) i_tmcap_timers (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shared_count_pin(pin_sh),
    .wide_timer_count_pin(pin_wd), .capture_one_pin(pin_c1), .capture_two_pin(pin_c2),
    .pwm_base_first(base1), .pwm_base_second(base2), .pwm_base_first_wrap(wrap1),
    .pwm_base_second_wrap(wrap2)
  );
  tmcap_pins_model i_tmcap_pins_model (
    .mclk(mclk), .shared_count_pin(pin_sh), .wide_timer_count_pin(pin_wd),
    .capture_one_pin(pin_c1), .capture_two_pin(pin_c2)
  );

  // Verdict and end of run
  task automatic stop_test;
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Bus cycles start right after an edge; an idle cycle follows each
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
    @(posedge mclk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("register %h", a), d, e);
  endtask

  // Cycles to the next first-timer wrap, sampled mid-cycle; bounded against a dead timer
  task automatic next_wrap(output int n, output logic w2);
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
      if (n > 1000)
      begin
        chk("wrap wait", 16'h0000, 16'h0001);
        stop_test();
      end
    end
    while (wrap1 !== 1'b1);
    w2 = wrap2;
    @(posedge mclk);
  endtask

  task automatic t_reset;
    rc(`TMCAP_OFS_CONTROL, 8'h00);
    rc(`TMCAP_OFS_FIRST_PERIOD, 8'hff);
    rc(`TMCAP_OFS_PCA_HIGH, 8'hff);
    rc(`TMCAP_OFS_WIDE_HIGH, 8'h00);
    rc(8'h20, 8'h00);
    wr(`TMCAP_OFS_CONTROL, 8'ha5);
    rc(`TMCAP_OFS_CONTROL, 8'ha5);
    wr(`TMCAP_OFS_CONTROL, 8'h5a);
    rc(`TMCAP_OFS_CONTROL, 8'h5a);
  endtask

  task automatic t_byte;
    int   n;
    logic w2;
    wr(`TMCAP_OFS_CONTROL, 8'h00);
    wr(`TMCAP_OFS_FIRST_PERIOD, 8'h03);
    wr(`TMCAP_OFS_ENABLE, 8'h02);
    next_wrap(n, w2);
    next_wrap(n, w2);
    chk("first wrap gap", 16'(n), 16'(4 * DIV));
    wr(`TMCAP_OFS_ENABLE, 8'h00);
    rc(`TMCAP_OFS_SECOND_COUNT, 8'h00);
    rc(`TMCAP_OFS_STATUS, 8'h01);
    wr(`TMCAP_OFS_STATUS, 8'h01);
    rc(`TMCAP_OFS_STATUS, 8'h00);
  endtask

  task automatic t_ext;
    wr(`TMCAP_OFS_CONTROL, 8'h03);
    wr(`TMCAP_OFS_FIRST_PERIOD, 8'hff);
    wr(`TMCAP_OFS_FIRST_COUNT, 8'h00);
    wr(`TMCAP_OFS_ENABLE, 8'h06);
    i_tmcap_pins_model.pulse(0, 5, 3);
    repeat (6) @(negedge mclk);
    chk("time base", {base2, base1}, 16'h0505);
    @(posedge mclk);
    rc(`TMCAP_OFS_FIRST_COUNT, 8'h05);
    rc(`TMCAP_OFS_SECOND_COUNT, 8'h05);
  endtask

  // Joined count starts at 0x00ff so the first wrap needs a carry into the high byte
  task automatic t_joined;
    int   n;
    logic w2;
    wr(`TMCAP_OFS_ENABLE, 8'h00);
    wr(`TMCAP_OFS_CONTROL, 8'h08);
    wr(`TMCAP_OFS_FIRST_PERIOD, 8'h01);
    wr(`TMCAP_OFS_SECOND_PERIOD, 8'h01);
    wr(`TMCAP_OFS_FIRST_COUNT, 8'hff);
    wr(`TMCAP_OFS_SECOND_COUNT, 8'h00);
    wr(`TMCAP_OFS_ENABLE, 8'h06);
    next_wrap(n, w2);
    chk("joined pair wrap", 16'(w2), 16'h0001);
    next_wrap(n, w2);
    chk("joined wrap gap", 16'(n), 16'(258 * DIV));
    wr(`TMCAP_OFS_ENABLE, 8'h00);
    rc(`TMCAP_OFS_STATUS, 8'h01);
    wr(`TMCAP_OFS_STATUS, 8'h1f);
  endtask

  task automatic t_wide;
    wr(`TMCAP_OFS_CONTROL, 8'h04);
    wr(`TMCAP_OFS_ENABLE, 8'h09);
    i_tmcap_pins_model.pulse(1, 7, 3);
    repeat (6) @(posedge mclk);
    rc(`TMCAP_OFS_WIDE_LOW, 8'h07);
    rc(`TMCAP_OFS_WIDE_HIGH, 8'h00);
  endtask

  // Wide timer on the instruction tick restarts at the pair value in period mode
  task automatic t_period;
    wr(`TMCAP_OFS_ENABLE, 8'h00);
    wr(`TMCAP_OFS_CONTROL, 8'h00);
    wr(`TMCAP_OFS_WIDE_LOW, 8'h00);
    wr(`TMCAP_OFS_PCA_LOW, 8'h03);
    wr(`TMCAP_OFS_PCA_HIGH, 8'h00);
    wr(`TMCAP_OFS_STATUS, 8'h1f);
    wr(`TMCAP_OFS_ENABLE, 8'h08);
    repeat (20) @(posedge mclk);
    wr(`TMCAP_OFS_ENABLE, 8'h09);
    rc(`TMCAP_OFS_STATUS, 8'h04);
  endtask

  // Wide count is k before the falling edge and k+128 before the rising one
  task automatic fire(input int ch, input int k, output logic [7:0] s);
    wr(`TMCAP_OFS_WIDE_LOW, 8'(k));
    i_tmcap_pins_model.drive(2 + ch, 1'b0, 8);
    wr(`TMCAP_OFS_WIDE_LOW, 8'(k + 128));
    i_tmcap_pins_model.drive(2 + ch, 1'b1, 8);
    rd(`TMCAP_OFS_STATUS, s);
    s = s & 8'h18;
  endtask

  // Finds one capture, then expects the next exactly n pulses later; prescaler residue is harmless
  task automatic t_cap(input int ch, input int m);
    int         n;
    int         k;
    logic [7:0] s;
    logic [7:0] cap;
    n = (m < 2) ? 1 : (m == 2) ? 4 : 16;
    cap = (ch == 0) ? `TMCAP_OFS_PCA_LOW : `TMCAP_OFS_CAP2_LOW;
    wr(`TMCAP_OFS_CONTROL, 8'(8'h04 | (m << (4 + 2 * ch))));
    k = 0;
    s = 8'h00;
    while (s == 8'h00 && k < 2 * n + 1)
    begin
      fire(ch, k, s);
      k++;
    end
    chk("capture seen", 16'(s), 16'(8'h08 << ch));
    wr(`TMCAP_OFS_STATUS, 8'h18);
    for (int i = 1; i <= n; i++)
    begin
      fire(ch, k, s);
      k++;
      chk("capture flag", 16'(s), (i == n) ? 16'(8'h08 << ch) : 16'h0000);
    end
    if (ch == 1)
      wr(cap, 8'h00);
    rc(cap, 8'(k - 1 + ((m == 0) ? 0 : 128)));
    wr(`TMCAP_OFS_STATUS, 8'h18);
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_byte();
    t_ext();
    t_joined();
    t_wide();
    t_period();
    for (int ch = 0; ch < 2; ch++)
      for (int m = 0; m < 4; m++)
        t_cap(ch, m);
    stop_test();
  end
endmodule // tb
`default_nettype wire
